// ===== irl_pkg.sv
// Constants, register map and carrier types of the interrupt request logic.
// Assumes a single core clock domain and an AXI4-Lite register bus.
package irl_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Sources, in fixed polling order (index 0 is polled first)
    localparam int NSRC = 10;
    localparam logic [3:0] SRC_EXT0 = 4'h0;
    localparam logic [3:0] SRC_UART2 = 4'h1;
    localparam logic [3:0] SRC_TMR0 = 4'h2;
    localparam logic [3:0] SRC_TWI = 4'h3;
    localparam logic [3:0] SRC_EXT1 = 4'h4;
    localparam logic [3:0] SRC_DISP = 4'h5;
    localparam logic [3:0] SRC_TMR1 = 4'h6;
    localparam logic [3:0] SRC_USB = 4'h7;
    localparam logic [3:0] SRC_UART1 = 4'h8;
    localparam logic [3:0] SRC_TMR2 = 4'h9;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_TIMER_CTRL = 8'h00;
    localparam logic [7:0] OFS_TMR2_CTRL = 8'h04;
    localparam logic [7:0] OFS_ENABLE = 8'h08;
    localparam logic [7:0] OFS_PRIO_FIRST = 8'h0C;
    localparam logic [7:0] OFS_PRIO_SECOND = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;

    // Field positions
    localparam int TC_EXT0_TRIG = 0;
    localparam int TC_EXT0_FLAG = 1;
    localparam int TC_EXT1_TRIG = 2;
    localparam int TC_EXT1_FLAG = 3;
    localparam int TC_TMR0_FLAG = 5;
    localparam int TC_TMR1_FLAG = 7;
    localparam int TC_ADC_SHARE = 8;
    localparam int T2_EXT_EN = 3;
    localparam int T2_EXT_FLAG = 6;
    localparam int T2_OVF_FLAG = 7;
    localparam int EN_GLOBAL = 31;
    localparam int PRIO_HALF = 5;
    localparam int ST_ACTIVE_HI = 16;
    localparam int ST_ACTIVE_LO = 17;
    localparam int ST_VEC_LSB = 24;

    // Reset values
    localparam logic [NSRC-1:0] EN_RESET = 10'h000;
    localparam logic [NSRC-1:0] PRIO_RESET = 10'h000;
    localparam logic PIN_IDLE = 1'b1;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    ////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [3:0] {
        SVC_IDLE = 4'h1,
        SVC_LOW = 4'h2,
        SVC_HIGH = 4'h4,
        SVC_NEST = 4'h8
    } irl_svc_e;

    typedef struct packed {
        logic uart2;
        logic twi;
        logic disp;
        logic usb;
        logic uart1;
        logic adc;
    } irl_periph_s;

    typedef struct packed {
        logic t0_ovf;
        logic t0_mode3;
        logic t1_ovf;
        logic t2_ovf;
    } irl_tmr_s;

endpackage

// ===== irl_pick.sv
// Fixed-order request picker: lowest index among the raised requests wins.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module irl_pick (
    input wire logic [irl_pkg::NSRC-1:0] req,
    output logic valid,
    output logic [3:0] idx
);
    import irl_pkg::*;

    always_comb begin
        valid = 1'b0;
        idx = 4'h0;
        // Walk downward so the lowest raised index is left standing
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (req[i]) begin
                valid = 1'b1;
                idx = 4'(i);
            end
        end
    end

endmodule

// ===== irl_top.sv
// Interrupt request logic: collects ten sources, keeps their flags,
// picks a winner by level and polling order and offers it to the core.
// Assumes the core pulses irq_ack when it vectors and irq_return when a
// routine ends; all inputs are synchronous to aclk.
//
// Overview of operation
// - Ten sources: ext zero, uart two, timer zero, twi, ext one, display, etc.
// - A control bit picks level or falling-edge triggering for ext line zero.
// - Ext line zero interrupts from its own request flag in timer control.
// - Edge mode: ext zero flag cleared by hardware when the core vectors.
// - Level mode: ext zero flag follows the pin, not cleared on vectoring.
// - Timer zero and one set overflow flags; timer zero in mode three does not.
// - Timer zero and one overflow flags clear when their interrupt is serviced.
// - Timer two overflow flag set on overflow, cleared only by software.
// - Timer two external pin edge, gated by enable, sets an external flag.
// - Ext line one request slot may be taken over by the analog converter.
// - Each source has a low or high priority; high may preempt low.
// - A high-priority routine is never preempted.
// - Equal-level requests resolved by fixed order, ext zero first, timer two last.
// - Per-source enables plus a global enable that masks all pending requests.
`timescale 1ns/1ps
module irl_top (
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [irl_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [irl_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Pins and peripherals
    input wire logic ext_irq_line_zero_n,
    input wire logic ext_irq_line_one_n,
    input wire logic tmr_two_external_pin,
    input wire irl_pkg::irl_tmr_s tmr_evt,
    input wire irl_pkg::irl_periph_s periph_req,
    // Core side
    input wire logic irq_ack,
    input wire logic irq_return,
    output logic irq_req,
    output logic [3:0] irq_vector,
    output logic irq_high
);
    import irl_pkg::*;

    typedef struct packed {
        logic ext0_trig;
        logic ext0_flag;
        logic ext1_trig;
        logic ext1_flag;
        logic adc_share;
        logic t0_flag;
        logic t1_flag;
        logic t2_flag;
        logic tmr_two_ext_flag_flag;
        logic t2_ext_en;
        logic ext0_prev;
        logic ext1_prev;
        logic tmr_two_external_pin_prev;
        irl_periph_s periph;
        logic [NSRC-1:0] en;
        logic gie;
        logic [NSRC-1:0] prio;
        irl_svc_e svc;
        logic req;
        logic [3:0] vec;
        logic hi;
        logic aw_got;
        logic w_got;
        logic [ADDR_W-1:0] awa;
        logic [31:0] wd;
        logic [3:0] ws;
        logic awready;
        logic wready;
        logic arready;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } irl_state_s;

    irl_state_s s;
    irl_state_s next_s;

    logic [NSRC-1:0] src_flag;
    logic [NSRC-1:0] pend;
    logic [NSRC-1:0] hi_in;
    logic [NSRC-1:0] lo_in;
    logic hi_v;
    logic lo_v;
    logic [3:0] hi_idx;
    logic [3:0] lo_idx;
    logic ack;
    logic [31:0] wmask;
    logic [31:0] wset;
    logic wr_fire;
    logic wr_tc;
    logic wr_t2;
    logic fall0;
    logic fall1;
    logic fall_tmr_two_external_pin;

    ////////////////////////////////////////////////////////////////////////////
    // Request vector and winner selection
    assign src_flag = {s.t2_flag | s.tmr_two_ext_flag_flag, s.periph.uart1, s.periph.usb, s.t1_flag,
                       s.periph.disp, s.ext1_flag, s.periph.twi, s.t0_flag,
                       s.periph.uart2, s.ext0_flag};
    assign pend = src_flag & s.en & {NSRC{s.gie}};
    // High level may enter idle or over a low routine, never over a high one
    assign hi_in = (s.svc == SVC_IDLE || s.svc == SVC_LOW) ? (pend & s.prio) : '0;
    assign lo_in = (s.svc == SVC_IDLE) ? (pend & ~s.prio) : '0;

    irl_pick u_pick_hi (
        .req(hi_in),
        .valid(hi_v),
        .idx(hi_idx)
    );

    irl_pick u_pick_lo (
        .req(lo_in),
        .valid(lo_v),
        .idx(lo_idx)
    );

    assign ack = irq_ack && s.req;
    assign wr_fire = s.aw_got && s.w_got && !s.bvalid;
    assign wr_tc = wr_fire && (s.awa == OFS_TIMER_CTRL);
    assign wr_t2 = wr_fire && (s.awa == OFS_TMR2_CTRL);
    assign wmask = {{8{s.ws[3]}}, {8{s.ws[2]}}, {8{s.ws[1]}}, {8{s.ws[0]}}};
    assign wset = s.wd & wmask;
    assign fall0 = s.ext0_prev && !ext_irq_line_zero_n;
    assign fall1 = s.ext1_prev && !ext_irq_line_one_n;
    assign fall_tmr_two_external_pin = s.tmr_two_external_pin_prev && !tmr_two_external_pin;

    function automatic logic [31:0] read_reg(input irl_state_s st, input logic [NSRC-1:0] pd);
        logic [31:0] d;
        d = 32'h0000_0000;
        case (st.awa)
            default: d = 32'h0000_0000;
        endcase
        return d;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        next_s = s;

        // Peripheral flags are owned outside; sampled every clock
        next_s.periph = periph_req;
        next_s.ext0_prev = ext_irq_line_zero_n;
        next_s.ext1_prev = ext_irq_line_one_n;
        next_s.tmr_two_external_pin_prev = tmr_two_external_pin;

        // Control bits
        if (wr_tc && wmask[TC_EXT0_TRIG]) begin
            next_s.ext0_trig = s.wd[TC_EXT0_TRIG];
        end
        if (wr_tc && wmask[TC_EXT1_TRIG]) begin
            next_s.ext1_trig = s.wd[TC_EXT1_TRIG];
        end
        if (wr_tc && wmask[TC_ADC_SHARE]) begin
            next_s.adc_share = s.wd[TC_ADC_SHARE];
        end
        if (wr_t2 && wmask[T2_EXT_EN]) begin
            next_s.t2_ext_en = s.wd[T2_EXT_EN];
        end
        if (wr_fire && s.awa == OFS_ENABLE) begin
            next_s.en = (s.en & ~wmask[NSRC-1:0]) | wset[NSRC-1:0];
            if (wmask[EN_GLOBAL]) begin
                next_s.gie = s.wd[EN_GLOBAL];
            end
        end
        if (wr_fire && s.awa == OFS_PRIO_FIRST) begin
            next_s.prio[PRIO_HALF-1:0] = (s.prio[PRIO_HALF-1:0] & ~wmask[PRIO_HALF-1:0])
                                       | wset[PRIO_HALF-1:0];
        end
        if (wr_fire && s.awa == OFS_PRIO_SECOND) begin
            next_s.prio[NSRC-1:PRIO_HALF] = (s.prio[NSRC-1:PRIO_HALF]
                                          & ~wmask[PRIO_HALF-1:0]) | wset[PRIO_HALF-1:0];
        end

        // Ext line zero: edge flag is sticky, level flag mirrors the pin
        if (s.ext0_trig) begin
            next_s.ext0_flag = fall0 | (s.ext0_flag & !(ack && s.vec == SRC_EXT0)
                             & !(wr_tc && wset[TC_EXT0_FLAG]));
        end else begin
            // A pin still low after the routine simply raises again
            next_s.ext0_flag = !ext_irq_line_zero_n;
        end

        // Ext line one, or the converter's done flag when shared
        if (s.adc_share) begin
            next_s.ext1_flag = s.periph.adc;
        end else if (s.ext1_trig) begin
            next_s.ext1_flag = fall1 | (s.ext1_flag & !(ack && s.vec == SRC_EXT1)
                             & !(wr_tc && wset[TC_EXT1_FLAG]));
        end else begin
            next_s.ext1_flag = !ext_irq_line_one_n;
        end

        // Timer flags: set beats any clear in the same cycle
        next_s.t0_flag = (tmr_evt.t0_ovf && !tmr_evt.t0_mode3)
                       | (s.t0_flag & !(ack && s.vec == SRC_TMR0)
                       & !(wr_tc && wset[TC_TMR0_FLAG]));
        next_s.t1_flag = tmr_evt.t1_ovf
                       | (s.t1_flag & !(ack && s.vec == SRC_TMR1)
                       & !(wr_tc && wset[TC_TMR1_FLAG]));
        next_s.t2_flag = tmr_evt.t2_ovf | (s.t2_flag & !(wr_t2 && wset[T2_OVF_FLAG]));
        next_s.tmr_two_ext_flag_flag = (fall_tmr_two_external_pin && s.t2_ext_en)
                         | (s.tmr_two_ext_flag_flag & !(wr_t2 && wset[T2_EXT_FLAG]));

        // Service nesting; an ack in the same cycle as a return takes precedence
        if (ack) begin
            case (s.svc)
                SVC_IDLE: next_s.svc = s.hi ? SVC_HIGH : SVC_LOW;
                SVC_LOW: next_s.svc = SVC_NEST;
                default: next_s.svc = s.svc;
            endcase
        end else if (irq_return) begin
            case (s.svc)
                SVC_NEST: next_s.svc = SVC_LOW;
                SVC_HIGH: next_s.svc = SVC_IDLE;
                SVC_LOW: next_s.svc = SVC_IDLE;
                default: next_s.svc = SVC_IDLE;
            endcase
        end

        // Offer to the core; dropped for one cycle after each ack
        next_s.req = !ack && (hi_v || lo_v);
        next_s.vec = hi_v ? hi_idx : lo_idx;
        next_s.hi = hi_v;

        // AXI write channels
        if (awvalid && s.awready) begin
            next_s.aw_got = 1'b1;
            next_s.awa = {awaddr[ADDR_W-1:2], 2'b00};
        end
        if (wvalid && s.wready) begin
            next_s.w_got = 1'b1;
            next_s.wd = wdata;
            next_s.ws = wstrb;
        end
        if (wr_fire) begin
            next_s.aw_got = 1'b0;
            next_s.w_got = 1'b0;
            next_s.bvalid = 1'b1;
            case (s.awa)
                OFS_TIMER_CTRL, OFS_TMR2_CTRL, OFS_ENABLE,
                OFS_PRIO_FIRST, OFS_PRIO_SECOND, OFS_STATUS: next_s.bresp = RESP_OKAY;
                default: next_s.bresp = RESP_SLVERR;
            endcase
        end
        if (s.bvalid && bready) begin
            next_s.bvalid = 1'b0;
        end
        next_s.awready = !next_s.aw_got && !next_s.bvalid;
        next_s.wready = !next_s.w_got && !next_s.bvalid;

        // AXI read channel
        if (arvalid && s.arready) begin
            next_s.rvalid = 1'b1;
            next_s.rresp = RESP_OKAY;
            next_s.rdata = 32'h0000_0000;
            case ({araddr[ADDR_W-1:2], 2'b00})
                OFS_TIMER_CTRL: begin
                    next_s.rdata[TC_EXT0_TRIG] = s.ext0_trig;
                    next_s.rdata[TC_EXT0_FLAG] = s.ext0_flag;
                    next_s.rdata[TC_EXT1_TRIG] = s.ext1_trig;
                    next_s.rdata[TC_EXT1_FLAG] = s.ext1_flag;
                    next_s.rdata[TC_TMR0_FLAG] = s.t0_flag;
                    next_s.rdata[TC_TMR1_FLAG] = s.t1_flag;
                    next_s.rdata[TC_ADC_SHARE] = s.adc_share;
                end
                OFS_TMR2_CTRL: begin
                    next_s.rdata[T2_EXT_EN] = s.t2_ext_en;
                    next_s.rdata[T2_EXT_FLAG] = s.tmr_two_ext_flag_flag;
                    next_s.rdata[T2_OVF_FLAG] = s.t2_flag;
                end
                OFS_ENABLE: begin
                    next_s.rdata[NSRC-1:0] = s.en;
                    next_s.rdata[EN_GLOBAL] = s.gie;
                end
                OFS_PRIO_FIRST: next_s.rdata[PRIO_HALF-1:0] = s.prio[PRIO_HALF-1:0];
                OFS_PRIO_SECOND: next_s.rdata[PRIO_HALF-1:0] = s.prio[NSRC-1:PRIO_HALF];
                OFS_STATUS: begin
                    next_s.rdata[NSRC-1:0] = pend;
                    next_s.rdata[ST_ACTIVE_HI] = (s.svc == SVC_HIGH) || (s.svc == SVC_NEST);
                    next_s.rdata[ST_ACTIVE_LO] = (s.svc == SVC_LOW) || (s.svc == SVC_NEST);
                    next_s.rdata[ST_VEC_LSB+3:ST_VEC_LSB] = s.vec;
                end
                default: next_s.rresp = RESP_SLVERR;
            endcase
        end
        if (s.rvalid && rready) begin
            next_s.rvalid = 1'b0;
        end
        next_s.arready = !next_s.rvalid;
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
            s.ext0_prev <= PIN_IDLE;
            s.ext1_prev <= PIN_IDLE;
            s.tmr_two_external_pin_prev <= PIN_IDLE;
            s.en <= EN_RESET;
            s.prio <= PRIO_RESET;
            s.svc <= SVC_IDLE;
        end else begin
            s <= next_s;
        end
    end

    assign awready = s.awready;
    assign wready = s.wready;
    assign bvalid = s.bvalid;
    assign bresp = s.bresp;
    assign arready = s.arready;
    assign rvalid = s.rvalid;
    assign rdata = s.rdata;
    assign rresp = s.rresp;
    assign irq_req = s.req;
    assign irq_vector = s.vec;
    assign irq_high = s.hi;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_ext0_edge_taken;
        s.ext0_trig && ack && s.vec == SRC_EXT0 && !fall0;
    endsequence

    sequence s_t0_taken;
        ack && s.vec == SRC_TMR0 && !tmr_evt.t0_ovf;
    endsequence

    sequence s_high_entered;
        ack && s.hi && (s.svc == SVC_IDLE || s.svc == SVC_LOW);
    endsequence

    a_edge_sets_flag: assert property (s.ext0_trig && fall0 |=> s.ext0_flag)
        else $error("ext zero edge did not set flag");
    a_edge_ack_clears: assert property (s_ext0_edge_taken |=> !s.ext0_flag)
        else $error("ext zero edge flag not cleared on ack");
    a_level_follows: assert property (!s.ext0_trig |=> s.ext0_flag == !$past(ext_irq_line_zero_n))
        else $error("ext zero level flag does not follow pin");
    a_mode3_blocks: assert property (!s.t0_flag && tmr_evt.t0_mode3 && !wr_tc |=> !s.t0_flag)
        else $error("timer zero flag set in mode three");
    a_t0_ack_clears: assert property (s_t0_taken |=> !s.t0_flag)
        else $error("timer zero flag not cleared on service");
    a_t2_holds_flag: assert property (s.t2_flag && !wr_t2 ##1 !wr_t2 |-> s.t2_flag)
        else $error("timer two flag cleared without software");
    a_tmr_two_ext_flag_gated: assert property (!s.t2_ext_en && !s.tmr_two_ext_flag_flag |=> !s.tmr_two_ext_flag_flag)
        else $error("external flag set while disabled");
    a_high_no_preempt: assert property (s_high_entered |=> !irq_req [*2])
        else $error("request offered during high routine");
    a_global_blocks: assert property (!s.gie |=> !irq_req)
        else $error("request offered with global enable clear");
    a_poll_order: assert property (hi_v |=> irq_vector == $past(hi_idx) && irq_high)
        else $error("winner not taken from high level first");

endmodule

// ===== irl_core_model.sv
// Core-side partner: takes offered requests and ends service routines.
// Assumes the irl_top core link; the bench steers it through accept and hold.
`timescale 1ns/1ps
module irl_core_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic irq_req,
    input wire logic accept,
    input wire logic hold,
    output logic irq_ack,
    output logic irq_return
);
    logic [1:0] depth;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_ack <= 1'b0;
            irq_return <= 1'b0;
            depth <= 2'h0;
        end else begin
            // Ack and return never share a cycle: the block drops such a return
            irq_ack <= accept && irq_req && !irq_ack && !irq_return;
            irq_return <= !hold && !accept && depth != 2'h0 && !irq_return && !irq_ack;
            depth <= depth + {1'b0, irq_ack && irq_req} - {1'b0, irq_return};
        end
    end
endmodule

// ===== tb.sv
// Self-checking bench for irl_top: AXI4-Lite tasks, pin and timer stimulus.
// Assumes irl_core_model as the core; all stimulus is synchronous to aclk.
`timescale 1ns/1ps
module tb;
    import irl_pkg::*;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, irq_ack, irq_return;
    logic irq_req, irq_high, accept, hold, p0_n, p1_n, p2;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb, irq_vector;
    logic [1:0] bresp, rresp;
    irl_tmr_s tmr_evt;
    irl_periph_s periph_req;
    int err_count, num_checks, i;
    logic [5:0] pmap [5] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h02};
    int pidx [5] = '{1, 3, 5, 7, 8};

    irl_top u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .ext_irq_line_zero_n(p0_n),
        .ext_irq_line_one_n(p1_n), .tmr_two_external_pin(p2), .tmr_evt(tmr_evt),
        .periph_req(periph_req), .irq_ack(irq_ack), .irq_return(irq_return),
        .irq_req(irq_req), .irq_vector(irq_vector), .irq_high(irq_high));
    irl_core_model u_core (.aclk(aclk), .aresetn(aresetn), .irq_req(irq_req),
        .accept(accept), .hold(hold), .irq_ack(irq_ack), .irq_return(irq_return));

    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task report_and_stop(input int extra);
        err_count += extra;
        $display("Checks %0d, errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t ns: got %h, expected %h", $time, got, exp);
        end
    endtask

    task wrc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (n == 40) report_and_stop(1);
        chk({30'h0, bresp}, {30'h0, er});
    endtask

    task rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
             input logic [1:0] er);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (n == 40) report_and_stop(1);
        chk(rdata & m, e);
        chk({30'h0, rresp}, {30'h0, er});
    endtask

    // One edge first so a just-taken offer is not seen again; then wait and take
    task serve(input logic [4:0] e);
        int n;
        @(posedge aclk);
        for (n = 0; n < 40 && irq_req !== 1'b1; n++) @(posedge aclk);
        if (n == 40) report_and_stop(1);
        chk({27'h0, irq_high, irq_vector}, {27'h0, e});
        accept <= 1'b1;
        for (n = 0; n < 40 && irq_ack !== 1'b1; n++) @(posedge aclk);
        accept <= 1'b0;
        if (n == 40) report_and_stop(1);
    endtask

    task quiet(input int k);
        repeat (k) begin
            @(posedge aclk);
            chk({31'h0, irq_req}, 32'h0);
        end
    endtask

    task tev(input logic [3:0] v);
        tmr_evt <= irl_tmr_s'(v);
        @(posedge aclk);
        tmr_evt <= '0;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, accept, hold} = '0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        wstrb = 4'hF;
        {p0_n, p1_n, p2} = {3{PIN_IDLE}};
        tmr_evt = '0;
        periph_req = '0;
        err_count = 0;
        num_checks = 0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        for (i = 0; i < 6; i++) rdc(8'(i * 4), 32'hFFFF_FFFF, 32'h0, RESP_OKAY);
        rdc(8'h18, 32'hFFFF_FFFF, 32'h0, RESP_SLVERR);
        wrc(8'h1C, 32'hFFFF_FFFF, RESP_SLVERR);
        wrc(OFS_ENABLE, 32'h8000_03FF, RESP_OKAY);
        for (i = 0; i < 5; i++) begin
            periph_req <= irl_periph_s'(pmap[i]);
            repeat (3) @(posedge aclk);
            rdc(OFS_STATUS, 32'h3FF, 32'h1 << pidx[i], RESP_OKAY);
        end
        periph_req <= '0;
        tev(4'hA);
        rdc(OFS_TIMER_CTRL, 32'hFFFF_FFFF, 32'hA0, RESP_OKAY);
        wrc(OFS_ENABLE, 32'h8000_0044, RESP_OKAY);
        serve({1'b0, SRC_TMR0});
        serve({1'b0, SRC_TMR1});
        rdc(OFS_TIMER_CTRL, 32'hFFFF_FFFF, 32'h0, RESP_OKAY);
        tev(4'hC);
        rdc(OFS_TIMER_CTRL, 32'hFFFF_FFFF, 32'h0, RESP_OKAY);
        wrc(OFS_ENABLE, 32'h0000_0044, RESP_OKAY);
        tev(4'h8);
        quiet(8);
        wrc(OFS_ENABLE, 32'h8000_0004, RESP_OKAY);
        serve({1'b0, SRC_TMR0});
        wrc(OFS_ENABLE, 32'h8000_0200, RESP_OKAY);
        tev(4'h1);
        serve({1'b0, SRC_TMR2});
        rdc(OFS_TMR2_CTRL, 32'hFFFF_FFFF, 32'h80, RESP_OKAY);
        wrc(OFS_TMR2_CTRL, 32'h80, RESP_OKAY);
        rdc(OFS_TMR2_CTRL, 32'hFFFF_FFFF, 32'h0, RESP_OKAY);
        p2 <= 1'b0;
        @(posedge aclk);
        rdc(OFS_TMR2_CTRL, 32'hFFFF_FFFF, 32'h0, RESP_OKAY);
        p2 <= 1'b1;
        wrc(OFS_TMR2_CTRL, 32'h08, RESP_OKAY);
        p2 <= 1'b0;
        @(posedge aclk);
        rdc(OFS_TMR2_CTRL, 32'hFFFF_FFFF, 32'h48, RESP_OKAY);
        serve({1'b0, SRC_TMR2});
        p2 <= 1'b1;
        wrc(OFS_TMR2_CTRL, 32'h40, RESP_OKAY);
        wrc(OFS_ENABLE, 32'h8000_0001, RESP_OKAY);
        p0_n <= 1'b0;
        serve({1'b0, SRC_EXT0});
        rdc(OFS_TIMER_CTRL, 32'hFFFF_FFFF, 32'h02, RESP_OKAY);
        serve({1'b0, SRC_EXT0});
        p0_n <= 1'b1;
        wrc(OFS_TIMER_CTRL, 32'h01, RESP_OKAY);
        rdc(OFS_TIMER_CTRL, 32'hFFFF_FFFF, 32'h01, RESP_OKAY);
        p0_n <= 1'b0;
        @(posedge aclk);
        rdc(OFS_TIMER_CTRL, 32'hFFFF_FFFF, 32'h03, RESP_OKAY);
        serve({1'b0, SRC_EXT0});
        rdc(OFS_TIMER_CTRL, 32'hFFFF_FFFF, 32'h01, RESP_OKAY);
        p0_n <= 1'b1;
        hold <= 1'b1;
        wrc(OFS_ENABLE, 32'h8000_0082, RESP_OKAY);
        periph_req <= irl_periph_s'(6'h24);
        serve({1'b0, SRC_UART2});
        periph_req <= irl_periph_s'(6'h04);
        quiet(6);
        wrc(OFS_PRIO_SECOND, 32'h04, RESP_OKAY);
        serve({1'b1, SRC_USB});
        wrc(OFS_PRIO_FIRST, 32'h02, RESP_OKAY);
        periph_req <= irl_periph_s'(6'h24);
        quiet(6);
        periph_req <= '0;
        hold <= 1'b0;
        wrc(OFS_PRIO_FIRST, 32'h0, RESP_OKAY);
        wrc(OFS_PRIO_SECOND, 32'h0, RESP_OKAY);
        wrc(OFS_TIMER_CTRL, 32'h100, RESP_OKAY);
        wrc(OFS_ENABLE, 32'h8000_0010, RESP_OKAY);
        periph_req <= irl_periph_s'(6'h01);
        serve({1'b0, SRC_EXT1});
        periph_req <= '0;
        wrc(OFS_TIMER_CTRL, 32'h04, RESP_OKAY);
        p1_n <= 1'b0;
        @(posedge aclk);
        rdc(OFS_TIMER_CTRL, 32'hFFFF_FFFF, 32'h0C, RESP_OKAY);
        wrc(OFS_TIMER_CTRL, 32'h0C, RESP_OKAY);
        rdc(OFS_TIMER_CTRL, 32'hFFFF_FFFF, 32'h04, RESP_OKAY);
        p1_n <= 1'b1;
        report_and_stop(0);
    end
endmodule
